// file: src/ufp_fifo_port.sv
// Byte-wide parallel FIFO port: strobed host bus, flags, wakeup and aux pins.
// Assumes pin inputs other than the strobes synchronous to clk; USB engine sits behind streams.
`timescale 1ns/10ps
`default_nettype none
module ufp_fifo_port import ufp_pkg::*; #(
	parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
	parameter int LED_CYCLES  = LED_CYCLES_DEF,
	parameter int DEPTH       = FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [BUS_W-1:0]  fifo_bus_i,
	output logic      [BUS_W-1:0]  fifo_bus_o,
	output logic                   fifo_bus_oe,
	input  wire logic              rd_strobe_n,
	input  wire logic              wr_strobe,
	output logic                   tx_space_flag_n,
	output logic                   tx_space_flag_oe,
	output logic                   rx_avail_flag_n,
	output logic                   rx_avail_flag_oe,
	input  wire logic              rx_avail_flag_n_i,
	output logic                   aux_pin_a_o,
	output logic                   aux_pin_a_oe,
	output logic                   aux_pin_b_o,
	output logic                   aux_pin_b_oe,
	output logic                   io_pulldown_en,
	input  wire logic              usb_rx_valid,
	input  wire logic [BUS_W-1:0]  usb_rx_data,
	output logic                   usb_rx_ready,
	output logic                   usb_tx_valid,
	output logic      [BUS_W-1:0]  usb_tx_data,
	input  wire logic              usb_tx_ready,
	input  wire logic              usb_configured,
	input  wire logic              usb_suspend,
	output logic                   usb_resume_req,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata
);
	localparam int WCW = $clog2(WAKE_CYCLES + 1);
	localparam int LCW = $clog2(LED_CYCLES + 1);
	localparam int GCW = $clog2(FLAG_GAP_CYC + 1);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic              rd_s1_r, rd_s2_r, rd_s3_r;
	logic              wr_s1_r, wr_s2_r, wr_s3_r;
	logic [BUS_W-1:0]  bus_d1_r, bus_d2_r;
	logic              rd_fall, rd_rise, wr_fall;
	logic              rx_out_valid, rx_pop;
	logic [BUS_W-1:0]  rx_out_data;
	logic              tx_in_ready;
	logic [BUS_W-1:0]  bus_o_r;
	logic              bus_oe_r;
	logic [GCW-1:0]    rx_gap_r, tx_gap_r;
	logic              tx_flag_n_r, tx_flag_oe_r;
	logic              rx_flag_n_r, rx_flag_oe_r;
	logic              cfg_wake_r, cfg_pd_r;
	ufp_aux_sel_type   aux_sel_a_r, aux_sel_b_r;
	logic [7:0]        rdata_r;
	logic              wake_mode;
	logic [WCW-1:0]    wake_cnt_r;
	logic              resume_req_r;
	logic              pulldown_r;
	logic              pwr_n_r;
	logic              tx_act, rx_act;
	logic [LCW-1:0]    led_cnt_r [2];
	logic              tx_led_n_r, rx_led_n_r, any_led_n_r;
	ufp_pin_type       aux_a_r, aux_b_r;

	// ----------------------------------------
	// Strobe synchronisers and edge detect
	// ----------------------------------------
	// Third stage is only history for the edge detector
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_s1_r <= 1'b1;
			rd_s2_r <= 1'b1;
			rd_s3_r <= 1'b1;
			wr_s1_r <= 1'b0;
			wr_s2_r <= 1'b0;
			wr_s3_r <= 1'b0;
		end else begin
			rd_s1_r <= rd_strobe_n;
			rd_s2_r <= rd_s1_r;
			rd_s3_r <= rd_s2_r;
			wr_s1_r <= wr_strobe;
			wr_s2_r <= wr_s1_r;
			wr_s3_r <= wr_s2_r;
		end
	end

	// Bus data delayed to line up with the second strobe stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_d1_r <= '0;
			bus_d2_r <= '0;
		end else begin
			bus_d1_r <= fifo_bus_i;
			bus_d2_r <= bus_d1_r;
		end
	end

	assign rd_fall = rd_s3_r & ~rd_s2_r;
	assign rd_rise = ~rd_s3_r & rd_s2_r;
	assign wr_fall = wr_s3_r & ~wr_s2_r;

	// ----------------------------------------
	// Receive path: USB to controller
	// ----------------------------------------
	assign rx_pop = rd_fall & rx_out_valid;

	ufp_fifo #(
		.WIDTH (BUS_W),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (usb_rx_valid),
		.in_ready  (usb_rx_ready),
		.in_data   (usb_rx_data),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out_data)
	);

	// Byte fetched at the falling edge stands while the strobe stays low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_o_r  <= '0;
			bus_oe_r <= 1'b0;
		end else begin
			bus_oe_r <= ~rd_s2_r;
			if (rx_pop) begin
				bus_o_r <= rx_out_data;
			end
		end
	end

	// ----------------------------------------
	// Transmit path: controller to USB
	// ----------------------------------------
	// A write while full is dropped; the controller is to watch the flag
	ufp_fifo #(
		.WIDTH (BUS_W),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (wr_fall),
		.in_ready  (tx_in_ready),
		.in_data   (bus_d2_r),
		.out_valid (usb_tx_valid),
		.out_ready (usb_tx_ready),
		.out_data  (usb_tx_data)
	);

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// Gap counters keep each flag inactive for the minimum time after a cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_gap_r <= '0;
			tx_gap_r <= '0;
		end else begin
			if (rd_rise) begin
				rx_gap_r <= GCW'(FLAG_GAP_CYC);
			end else if (rx_gap_r != '0) begin
				rx_gap_r <= rx_gap_r - GCW'(1);
			end
			if (wr_fall) begin
				tx_gap_r <= GCW'(FLAG_GAP_CYC);
			end else if (tx_gap_r != '0) begin
				tx_gap_r <= tx_gap_r - GCW'(1);
			end
		end
	end

	assign wake_mode = cfg_wake_r & usb_suspend;

	// Enables reset low so both flags float in reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_flag_n_r  <= 1'b1;
			tx_flag_oe_r <= 1'b0;
			rx_flag_n_r  <= 1'b1;
			rx_flag_oe_r <= 1'b0;
		end else begin
			tx_flag_oe_r <= 1'b1;
			tx_flag_n_r  <= ~tx_in_ready | wr_fall | (tx_gap_r != '0);
			rx_flag_oe_r <= ~wake_mode;
			rx_flag_n_r  <= ~rx_out_valid | ~rd_s2_r | rd_rise | (rx_gap_r != '0);
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// Power-enable used as a power switch wants the pull-down bit set as well
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_wake_r  <= CFG_RST[CFG_WAKE_BIT];
			cfg_pd_r    <= CFG_RST[CFG_PD_BIT];
			aux_sel_a_r <= AUX_A_RST;
			aux_sel_b_r <= AUX_B_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CFG: begin
					cfg_wake_r <= reg_wdata[CFG_WAKE_BIT];
					cfg_pd_r   <= reg_wdata[CFG_PD_BIT];
				end
				REG_AUX_A: aux_sel_a_r <= ufp_aux_sel_type'(reg_wdata[2:0]);
				REG_AUX_B: aux_sel_b_r <= ufp_aux_sel_type'(reg_wdata[2:0]);
				default: ;
			endcase
		end
	end

	// Read data stands for one cycle only; unmapped reads give zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CFG: begin
					rdata_r               <= '0;
					rdata_r[CFG_WAKE_BIT] <= cfg_wake_r;
					rdata_r[CFG_PD_BIT]   <= cfg_pd_r;
				end
				REG_AUX_A: rdata_r <= {5'h00, aux_sel_a_r};
				REG_AUX_B: rdata_r <= {5'h00, aux_sel_b_r};
				REG_STATUS: begin
					rdata_r               <= '0;
					rdata_r[ST_RX_AVAIL]  <= rx_out_valid;
					rdata_r[ST_TX_FULL]   <= ~tx_in_ready;
					rdata_r[ST_SUSPEND]   <= usb_suspend;
					rdata_r[ST_CONFIGD]   <= usb_configured;
					rdata_r[ST_WAKE_MODE] <= wake_mode;
				end
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	// ----------------------------------------
	// Remote wakeup and suspend pull-down
	// ----------------------------------------
	// Counter saturates so one hold gives exactly one resume request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake_cnt_r   <= '0;
			resume_req_r <= 1'b0;
		end else begin
			resume_req_r <= wake_mode & ~rx_avail_flag_n_i & (wake_cnt_r == WCW'(WAKE_CYCLES - 1));
			if (!wake_mode || rx_avail_flag_n_i) begin
				wake_cnt_r <= '0;
			end else if (wake_cnt_r != WCW'(WAKE_CYCLES)) begin
				wake_cnt_r <= wake_cnt_r + WCW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pulldown_r <= 1'b0;
		end else begin
			pulldown_r <= cfg_pd_r & usb_suspend;
		end
	end

	// ----------------------------------------
	// Power enable and activity indicators
	// ----------------------------------------
	assign tx_act = usb_tx_valid & usb_tx_ready;
	assign rx_act = usb_rx_valid & usb_rx_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwr_n_r <= 1'b1;
		end else begin
			pwr_n_r <= usb_suspend | ~usb_configured;
		end
	end

	// Each transfer restarts a stretch so short bursts stay visible on an LED
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 2; i++) begin
				led_cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? tx_act : rx_act) begin
					led_cnt_r[i] <= LCW'(LED_CYCLES - 1);
				end else if (led_cnt_r[i] != '0) begin
					led_cnt_r[i] <= led_cnt_r[i] - LCW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_led_n_r  <= 1'b1;
			rx_led_n_r  <= 1'b1;
			any_led_n_r <= 1'b1;
		end else begin
			tx_led_n_r  <= ~(tx_act | (led_cnt_r[0] != '0));
			rx_led_n_r  <= ~(rx_act | (led_cnt_r[1] != '0));
			any_led_n_r <= ~(tx_act | rx_act | (led_cnt_r[0] != '0) | (led_cnt_r[1] != '0));
		end
	end

	// ----------------------------------------
	// Auxiliary pins
	// ----------------------------------------
	function automatic ufp_pin_type aux_drive(input ufp_aux_sel_type sel, input logic [3:0] src);
		ufp_pin_type p;
		p = PIN_RST;
		case (sel)
			AUX_TRI:    p = PIN_RST;
			AUX_DRIVE1: p = '{oe: 1'b1, lvl: 1'b1};
			AUX_DRIVE0: p = '{oe: 1'b1, lvl: 1'b0};
			AUX_POWER_ENABLE_N:  p = '{oe: 1'b1, lvl: src[0]};
			AUX_TX_ACTIVITY_LED_N:  p = '{oe: 1'b1, lvl: src[1]};
			AUX_RX_ACTIVITY_LED_N:  p = '{oe: 1'b1, lvl: src[2]};
			AUX_ANYLED: p = '{oe: 1'b1, lvl: src[3]};
			default:    p = PIN_RST;
		endcase
		return p;
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aux_a_r <= PIN_RST;
			aux_b_r <= PIN_RST;
		end else begin
			aux_a_r <= aux_drive(aux_sel_a_r, {any_led_n_r, rx_led_n_r, tx_led_n_r, pwr_n_r});
			aux_b_r <= aux_drive(aux_sel_b_r, {any_led_n_r, rx_led_n_r, tx_led_n_r, pwr_n_r});
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign fifo_bus_o       = bus_o_r;
	assign fifo_bus_oe      = bus_oe_r;
	assign tx_space_flag_n  = tx_flag_n_r;
	assign tx_space_flag_oe = tx_flag_oe_r;
	assign rx_avail_flag_n  = rx_flag_n_r;
	assign rx_avail_flag_oe = rx_flag_oe_r;
	assign aux_pin_a_o      = aux_a_r.lvl;
	assign aux_pin_a_oe     = aux_a_r.oe;
	assign aux_pin_b_o      = aux_b_r.lvl;
	assign aux_pin_b_oe     = aux_b_r.oe;
	assign io_pulldown_en   = pulldown_r;
	assign usb_resume_req   = resume_req_r;
	assign reg_rdata        = rdata_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RD_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
		rx_pop |=> bus_oe_r && (bus_o_r == $past(rx_out_data)))
		else $error("read byte not driven after read strobe fall");

	AST_RD_POP: assert property (@(posedge clk) disable iff (!rstn)
		$fell(rd_s2_r) && rx_out_valid |-> rx_pop)
		else $error("receive FIFO not advanced on read strobe fall");

	AST_WR_PUSH: assert property (@(posedge clk) disable iff (!rstn)
		wr_fall && tx_in_ready && !usb_tx_valid |=> usb_tx_valid && (usb_tx_data == $past(bus_d2_r)))
		else $error("written byte not at transmit FIFO head");

	AST_TXE_FULL: assert property (@(posedge clk) disable iff (!rstn)
		!tx_in_ready |=> tx_space_flag_n && tx_space_flag_oe)
		else $error("transmit-space flag low while transmit FIFO full");

	AST_RESET_TRI: assert property (@(posedge clk)
		!rstn |-> !tx_space_flag_oe && !rx_avail_flag_oe)
		else $error("flag driven during reset");

	AST_RXF_EMPTY: assert property (@(posedge clk) disable iff (!rstn)
		!rx_out_valid |=> rx_avail_flag_n)
		else $error("receive flag low with nothing to read");

	AST_WAKE_INPUT: assert property (@(posedge clk) disable iff (!rstn)
		cfg_wake_r && usb_suspend |=> !rx_avail_flag_oe)
		else $error("receive flag still driven in wakeup mode");

	AST_WAKE_REQ: assert property (@(posedge clk) disable iff (!rstn)
		usb_resume_req |-> $past(wake_cnt_r) == WCW'(WAKE_CYCLES - 1) && $past(wake_mode))
		else $error("resume request without full hold time");

	AST_PULLDOWN: assert property (@(posedge clk) disable iff (!rstn)
		##1 io_pulldown_en == $past(cfg_pd_r && usb_suspend))
		else $error("pull-down does not follow option and suspend");

	AST_AUX_TRI: assert property (@(posedge clk) disable iff (!rstn)
		aux_sel_a_r == AUX_TRI ##1 aux_sel_a_r == AUX_TRI |-> !aux_pin_a_oe)
		else $error("aux pin driven in float option");

	AST_POWER_ENABLE_N: assert property (@(posedge clk) disable iff (!rstn)
		usb_suspend ##1 aux_sel_a_r == AUX_POWER_ENABLE_N |=> aux_pin_a_o && aux_pin_a_oe)
		else $error("power-enable not high in suspend");

	AST_TX_ACTIVITY_LED_N: assert property (@(posedge clk) disable iff (!rstn)
		tx_act |=> !tx_led_n_r ##1 (led_cnt_r[0] != '0 || LED_CYCLES == 1))
		else $error("transmit activity pulse missing");

	AST_RX_ACTIVITY_LED_N: assert property (@(posedge clk) disable iff (!rstn)
		rx_act |=> !rx_led_n_r && !any_led_n_r)
		else $error("receive activity pulse missing");

	AST_ANYLED: assert property (@(posedge clk) disable iff (!rstn)
		tx_act |=> !any_led_n_r)
		else $error("combined activity pulse missing on transmit");

	COV_READ:   cover property (@(posedge clk) disable iff (!rstn) rx_pop ##1 bus_oe_r);
	COV_WRITE:  cover property (@(posedge clk) disable iff (!rstn) wr_fall && tx_in_ready);
	COV_FULL:   cover property (@(posedge clk) disable iff (!rstn) !tx_in_ready ##1 usb_tx_ready);
	COV_RESUME: cover property (@(posedge clk) disable iff (!rstn) usb_resume_req);
endmodule
`default_nettype wire

// file: src/ufp_pkg.sv
// Shared constants and types for the byte-wide parallel FIFO port.
// Assumes a single 20 MHz clock and a plain register port of 8-bit data.
package ufp_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ          = 20_000_000;
	localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
	localparam int WAKE_HOLD_MS    = 20;
	localparam int WAKE_CYCLES_DEF = (CLK_HZ / 1000) * WAKE_HOLD_MS;
	localparam int FLAG_GAP_NS     = 80;
	localparam int FLAG_GAP_CYC    = (FLAG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LED_CYCLES_DEF  = 16;

	// ----------------------------------------
	// Data path sizes
	// ----------------------------------------
	localparam int BUS_W      = 8;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam int          REG_AW      = 4;
	localparam logic [3:0]  REG_CFG     = 4'h0;
	localparam logic [3:0]  REG_AUX_A   = 4'h1;
	localparam logic [3:0]  REG_AUX_B   = 4'h2;
	localparam logic [3:0]  REG_STATUS  = 4'h3;
	localparam int          CFG_WAKE_BIT = 0;
	localparam int          CFG_PD_BIT   = 1;
	localparam logic [7:0]  CFG_RST      = 8'h00;
	localparam int          ST_RX_AVAIL  = 0;
	localparam int          ST_TX_FULL   = 1;
	localparam int          ST_SUSPEND   = 2;
	localparam int          ST_CONFIGD   = 3;
	localparam int          ST_WAKE_MODE = 4;

	// ----------------------------------------
	// Auxiliary pin signal options
	// ----------------------------------------
	typedef enum logic [2:0] {
		AUX_TRI    = 3'b000,
		AUX_DRIVE1 = 3'b001,
		AUX_DRIVE0 = 3'b010,
		AUX_POWER_ENABLE_N  = 3'b011,
		AUX_TX_ACTIVITY_LED_N  = 3'b100,
		AUX_RX_ACTIVITY_LED_N  = 3'b101,
		AUX_ANYLED = 3'b110
	} ufp_aux_sel_type;

	localparam ufp_aux_sel_type AUX_A_RST = AUX_TRI;
	localparam ufp_aux_sel_type AUX_B_RST = AUX_TRI;

	// Level and enable of one three-state pin
	typedef struct packed {
		logic oe;
		logic lvl;
	} ufp_pin_type;

	localparam ufp_pin_type PIN_RST = 2'b00;

endpackage

// file: src/ufp_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock; writes when full and reads when empty are refused.
`timescale 1ns/10ps
`default_nettype none
module ufp_fifo import ufp_pkg::*; #(
	parameter int WIDTH = BUS_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             in_ready_r;
	logic             out_valid_r;
	logic             push;
	logic             pop;

	assign push      = in_valid & in_ready_r;
	assign pop       = out_valid_r & out_ready;
	assign cnt_nxt   = cnt_r + CW'(push) - CW'(pop);
	assign in_ready  = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data  = mem_r[rptr_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wptr_r] <= in_data;
		end
	end

	// Flags come from the next count so that they stand registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_r      <= '0;
			rptr_r      <= '0;
			cnt_r       <= '0;
			in_ready_r  <= 1'b1;
			out_valid_r <= 1'b0;
		end else begin
			if (push) begin
				wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
			end
			if (pop) begin
				rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + AW'(1);
			end
			cnt_r       <= cnt_nxt;
			in_ready_r  <= (cnt_nxt != CW'(DEPTH));
			out_valid_r <= (cnt_nxt != '0);
		end
	end
endmodule
`default_nettype wire

// file: verification/ufp_host_model.sv
// Host controller model that strobes the parallel FIFO port.
// Assumes the flag pins and the settled bus level are fed back in.
`timescale 1ns/10ps
`default_nettype none
module ufp_host_model import ufp_pkg::*; (
	input  wire logic             clk,
	input  wire logic             tx_flag_n,
	input  wire logic             rx_flag_n,
	input  wire logic [BUS_W-1:0] bus_in,
	output logic                  rd_n,
	output logic                  wr,
	output logic      [BUS_W-1:0] bus_drv
);
	int tmo = 0;
	initial begin
		rd_n = 1'b1;
		wr = 1'b0;
		bus_drv = 8'h00;
	end
	task automatic wait_low(input bit rx);
		int n;
		n = 0;
		while ((rx ? rx_flag_n : tx_flag_n) !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n == 200) tmo++;
	endtask
	task automatic put(input logic [BUS_W-1:0] b);
		wait_low(1'b0);
		bus_drv <= b;
		wr <= 1'b1;
		repeat (2) @(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
		// Released data must not look like the byte just written
		bus_drv <= ~b;
		repeat (2) @(posedge clk);
	endtask
	task automatic get(output logic [BUS_W-1:0] b);
		wait_low(1'b1);
		rd_n <= 1'b0;
		repeat (4) @(posedge clk);
		b = bus_in;
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: verification/ufp_fifo_port_tb.sv
// Self-checking bench for the parallel FIFO port, with queue model.
// Assumes the host model on the strobes and the bench on the USB side.
`timescale 1ns/10ps
`default_nettype none
module ufp_fifo_port_tb import ufp_pkg::*; ;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic [BUS_W-1:0] bus_o, bus_drv, rxd, txd, rdata, b;
	logic             bus_oe, rd_n, wr, txf_n, txf_oe, rxf_n, rxf_oe, a_o, a_oe, b_o, b_oe, pd, rxr, txv, res;
	logic             rxv = 0, txr = 0, cfgd = 0, susp = 0, rwr = 0, rrd = 0, wake_n = 1;
	logic [REG_AW-1:0] addr = '0;
	logic [7:0]       wdata = '0;
	int               miscompares = 0, compares = 0, la = 0, lb = 0, la0 = 0, lb0 = 0;
	logic [BUS_W-1:0] q[$];
	wire logic [BUS_W-1:0] bus = bus_oe ? bus_o : bus_drv;
	wire logic        rxf_pin = rxf_oe ? rxf_n : wake_n;
	always #25 clk = ~clk;
	always @(negedge clk) begin
		if (a_oe && !a_o) la++;
		if (b_oe && !b_o) lb++;
	end
	ufp_fifo_port #(.WAKE_CYCLES(20), .LED_CYCLES(4), .DEPTH(FIFO_DEPTH)) ufp_fifo_port_inst (
		.clk(clk), .rstn(rstn), .fifo_bus_i(bus), .fifo_bus_o(bus_o), .fifo_bus_oe(bus_oe),
		.rd_strobe_n(rd_n), .wr_strobe(wr), .tx_space_flag_n(txf_n), .tx_space_flag_oe(txf_oe),
		.rx_avail_flag_n(rxf_n), .rx_avail_flag_oe(rxf_oe), .rx_avail_flag_n_i(rxf_pin),
		.aux_pin_a_o(a_o), .aux_pin_a_oe(a_oe), .aux_pin_b_o(b_o), .aux_pin_b_oe(b_oe),
		.io_pulldown_en(pd), .usb_rx_valid(rxv), .usb_rx_data(rxd), .usb_rx_ready(rxr),
		.usb_tx_valid(txv), .usb_tx_data(txd), .usb_tx_ready(txr), .usb_configured(cfgd),
		.usb_suspend(susp), .usb_resume_req(res), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(rwr), .reg_rd(rrd), .reg_rdata(rdata));
	ufp_host_model ufp_host_model_inst (.clk(clk), .tx_flag_n(txf_n), .rx_flag_n(rxf_n),
		.bus_in(bus), .rd_n(rd_n), .wr(wr), .bus_drv(bus_drv));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic reg_w(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
		// One idle edge so a following call never re-assigns the strobe in the same step
		@(posedge clk);
	endtask
	task automatic reg_r(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	// Caller lowers valid after the last byte so it is never driven twice per step
	task automatic push_rx(input logic [7:0] d);
		bit ok;
		int n;
		n = 0;
		rxv <= 1'b1;
		rxd <= d;
		do begin
			@(negedge clk);
			ok = rxr;
			@(posedge clk);
			n++;
		end while (!ok && n < 50);
		if (!ok) miscompares++;
	endtask
	initial begin
		int n;
		void'($urandom(32'h238c56e4));
		rxd = '0;
		repeat (2) @(posedge clk);
		check({6'h0, txf_oe, rxf_oe}, 8'h00);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		check({4'h0, txf_oe, rxf_oe, txf_n, rxf_n}, 8'h0d);
		cfgd <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			reg_w(REG_AUX_B, 8'(i));
			repeat (4) @(posedge clk);
			check({6'h0, b_oe, b_oe & b_o}, i == 0 ? 8'h00 : i == 1 ? 8'h03 : 8'h02);
		end
		// ---------------------------------------------
		// Transmit: fill with USB stalled, then drain
		// ---------------------------------------------
		reg_w(REG_AUX_A, 8'(AUX_TX_ACTIVITY_LED_N));
		reg_w(REG_AUX_B, 8'(AUX_ANYLED));
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			b = 8'($urandom);
			q.push_back(b);
			ufp_host_model_inst.put(b);
		end
		check({7'h0, txf_n}, 8'h01);
		la0 = la;
		lb0 = lb;
		txr <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (txv === 1'b1 && q.size() > 0) check(txd, q.pop_front());
			@(posedge clk);
		end
		check({5'h0, la > la0, lb > lb0, txf_n}, 8'h06);
		check({4'h0, 4'(q.size())}, 8'h00);
		check({6'h0, a_o, b_o}, 8'h03);
		// ---------------------------------------------
		// Receive: fill until refused, read back
		// ---------------------------------------------
		reg_w(REG_AUX_A, 8'(AUX_ANYLED));
		reg_w(REG_AUX_B, 8'(AUX_RX_ACTIVITY_LED_N));
		la0 = la;
		lb0 = lb;
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			b = 8'($urandom);
			q.push_back(b);
			push_rx(b);
		end
		rxv <= 1'b0;
		@(negedge clk);
		check({5'h0, la > la0, lb > lb0, rxr}, 8'h06);
		@(posedge clk);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			ufp_host_model_inst.get(b);
			check(b, q.pop_front());
		end
		check({7'h0, rxf_n}, 8'h01);
		reg_r(4'hf, b);
		check(b, 8'h00);
		// ---------------------------------------------
		// Suspend, pull-down and remote wakeup
		// ---------------------------------------------
		reg_w(REG_AUX_A, 8'(AUX_POWER_ENABLE_N));
		reg_w(REG_AUX_B, 8'(AUX_POWER_ENABLE_N));
		reg_w(REG_CFG, 8'h03);
		susp <= 1'b1;
		repeat (4) @(posedge clk);
		check({5'h0, rxf_oe, pd, b_oe & b_o}, 8'h03);
		reg_r(REG_STATUS, b);
		check(b, 8'((1 << ST_SUSPEND) | (1 << ST_CONFIGD) | (1 << ST_WAKE_MODE)));
		wake_n <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (res !== 1'b1 && n < 60);
		check({7'h0, n >= 20 && n < 60}, 8'h01);
		check(8'(ufp_host_model_inst.tmo), 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
